// File: pkg/sr_one_pkg.sv
// Purpose: Constants and types shared by the status register one block.
// Assumes: 250 MHz core clock, 8 Mbit array, SPI mode 0 command framing.
// Notes: Bit 7 of the status byte belongs to other logic and reads as zero.
package sr_one_pkg;

    // Core clock period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;

    // Time the non-volatile copy takes to update after a latched write
    localparam int NV_WRITE_NS = 1000;
    localparam int NV_WRITE_CYC = (NV_WRITE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [9:0] NV_WRITE_CNT = NV_WRITE_CYC[9:0];

    // Serial command codes
    localparam logic [7:0] CMD_WRITE_EN = 8'h06;
    localparam logic [7:0] CMD_VOL_WRITE_EN = 8'h50;
    localparam logic [7:0] CMD_READ_DIRECT = 8'h05;
    localparam logic [7:0] CMD_WRITE_DIRECT = 8'h01;
    localparam logic [7:0] CMD_READ_INDIRECT = 8'h65;
    localparam logic [7:0] CMD_WRITE_INDIRECT = 8'h71;
    localparam logic [7:0] REG_ADDR_ONE = 8'h01;

    // Field positions inside the status byte
    localparam int POS_GRANULARITY = 6;
    localparam int POS_DIRECTION = 5;
    localparam int POS_RANGE_LO = 2;
    localparam int POS_LATCH = 1;
    localparam int POS_BUSY = 0;

    // Range codes: value after reset, and all protected
    localparam logic [2:0] RANGE_RESET = 3'h0;
    localparam logic [2:0] RANGE_ALL = 3'h7;

    // Array geometry in bytes
    localparam logic [21:0] MEM_BYTES = 22'h100000;
    localparam logic [21:0] BLK_FINE = 22'h001000;
    localparam logic [21:0] BLK_COARSE = 22'h010000;

    // Settings written by the host
    typedef struct packed {
        logic granularity;
        logic direction;
        logic [2:0] range;
    } protect_t;

    // Synchronised serial pins
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } spi_pins_t;

    // Receiver states
    typedef enum logic [4:0] {
        ST_CMD = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_READ = 5'b01000,
        ST_IGNORE = 5'b10000
    } rx_state_t;

endpackage : sr_one_pkg

// File: rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for the serial pins.
// Assumes: Pins are asynchronous to clk.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import sr_one_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire spi_pins_t pins_in, // Raw pins
    output var spi_pins_t pins_out // Synchronised pins
);

    // First stage, read only by the second
    spi_pins_t stage1;

    // One flop pair per pin; chip select idles high
    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                begin
                    stage1[i] <= (i == 2) ? 1'b1 : 1'b0;
                    pins_out[i] <= (i == 2) ? 1'b1 : 1'b0;
                end
                else
                begin
                    stage1[i] <= pins_in[i];
                    pins_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync
`default_nettype wire

// File: rtl/status_one_protect_ready.sv
// Purpose: Status register one (protection fields, write latch, busy flag).
// Assumes: SPI mode 0; pins sampled by clk at well above the serial rate.
// Notes: Commands execute on chip select rising, only when whole bytes arrived.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Granularity one means 4 kB blocks
// - Direction zero bottom up, one top down
// - Direction applies to range at bits 4:2
// - Direct write 01h updates the range field
// - Range resets to zero, nothing protected; the code loads the non-volatile copy in the cycle after reset
// - Refuse program/erase into protected region
// - Latch zero ignores writes not armed by 50h, programs, erases
// - Latch clears at power-up and reset
// - Aborted incomplete command keeps latch set
// - Only complete commands may consume the latch
// - Write enable 06h sets the latch
// - Volatile enable 50h leaves latch unchanged
// - Busy flag one while operation runs
// - Each status read byte is refreshed
// - Bits 6,5,4:2,1,0 hold the fields
// - Direct 05h or indirect 65h+01h reads
// - Power-up loads bits from non-volatile copy
module status_one_protect_ready
    import sr_one_pkg::*;
(
    input wire logic clk, // Core clock, 250 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic cs_n_pin, // Chip select pin, active low
    input wire logic sclk_pin, // Serial clock pin
    input wire logic mosi_pin, // Serial data in pin
    input wire protect_t nv_image, // Non-volatile copy of the settings
    input wire logic ext_busy, // Array operation in progress
    input wire logic pe_req, // Program or erase request pulse
    input wire logic [19:0] pe_addr, // Target byte address of the request
    output logic miso, // Serial data out
    output logic miso_en_n, // Output enable for miso, low drives
    output logic pe_grant, // Request accepted pulse
    output logic pe_refuse, // Request refused pulse
    output var protect_t nv_write_data, // Value for the non-volatile copy
    output logic nv_write_start // Pulse, non-volatile update begins
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Whether an address falls into the protected region
    function automatic logic is_protected(input protect_t p, input logic [19:0] a);
        logic [21:0] size;
        size = p.granularity ? BLK_FINE : BLK_COARSE;
        size = size << (p.range - 3'h1);
        if (p.range == RANGE_RESET)
            return 1'b0;
        if (p.range == RANGE_ALL || size >= MEM_BYTES)
            return 1'b1;
        if (p.direction)
            return {2'h0, a} >= (MEM_BYTES - size);
        return {2'h0, a} < size;
    endfunction : is_protected

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    spi_pins_t raw; // Pins as they arrive
    spi_pins_t pins; // Pins after two flops
    logic sclk_q; // Previous serial clock
    logic cs_q; // Previous chip select
    assign raw = '{cs_n: cs_n_pin, sclk: sclk_pin, mosi: mosi_pin};

    pin_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pins_in(raw),
        .pins_out(pins)
    );

    // Delayed copies for edges
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end
        else
        begin
            sclk_q <= pins.sclk;
            cs_q <= pins.cs_n;
        end
    end

    logic sclk_rise, sclk_fall, cs_end, selected;
    assign selected = !pins.cs_n;
    assign sclk_rise = selected && pins.sclk && !sclk_q;
    assign sclk_fall = selected && !pins.sclk && sclk_q;
    assign cs_end = pins.cs_n && !cs_q;

    ////////////////////////////////////////////////////////////////////////
    // Register state

    protect_t prot; // Protection settings
    logic write_latch; // Write enable latch
    logic busy_flag; // Ready/busy as seen by the host
    logic vol_enable; // Volatile write armed by 50h
    logic op_active; // Accepted operation still running
    logic [9:0] nv_cnt; // Non-volatile update timer
    logic load_done; // Power-up copy taken
    logic [7:0] status_byte;
    assign status_byte = {1'b0, prot.granularity, prot.direction, prot.range,
                          write_latch, busy_flag};

    ////////////////////////////////////////////////////////////////////////
    // Command receiver

    rx_state_t state; // Receiver state
    logic [2:0] bit_cnt; // Bit within current byte
    logic [6:0] shift_in; // Bits gathered so far
    logic [7:0] cmd; // Command byte
    logic cmd_full; // Command byte complete
    logic data_full; // Data byte complete
    logic byte_odd; // Partial byte pending
    logic ind_write; // Indirect form is a write
    logic [7:0] data; // Captured data byte
    logic reload; // Next falling edge loads fresh status
    logic [7:0] rx_byte;
    assign rx_byte = {shift_in, pins.mosi};

    // Shift in on rising edges and walk the command framing
    always_ff @(posedge clk)
    begin
        if (!reset_n || !selected)
        begin
            state <= ST_CMD;
            bit_cnt <= 3'h0;
            shift_in <= 7'h00;
            cmd <= 8'h00;
            cmd_full <= 1'b0;
            data_full <= 1'b0;
            byte_odd <= 1'b0;
            ind_write <= 1'b0;
            data <= 8'h00;
            reload <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_in <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            byte_odd <= (bit_cnt != 3'h7);
            reload <= 1'b0;
            if (bit_cnt == 3'h7)
            begin
                case (state)
                    ST_CMD:
                    begin
                        cmd <= rx_byte;
                        cmd_full <= 1'b1;
                        ind_write <= (rx_byte == CMD_WRITE_INDIRECT);
                        if (rx_byte == CMD_READ_DIRECT)
                        begin
                            state <= ST_READ;
                            reload <= 1'b1;
                        end
                        else if (rx_byte == CMD_WRITE_DIRECT)
                            state <= ST_DATA;
                        else if (rx_byte == CMD_READ_INDIRECT || rx_byte == CMD_WRITE_INDIRECT)
                            state <= ST_ADDR;
                        else
                            state <= ST_IGNORE;
                    end
                    ST_ADDR:
                    begin
                        if (rx_byte != REG_ADDR_ONE)
                            state <= ST_IGNORE;
                        else if (ind_write)
                            state <= ST_DATA;
                        else
                        begin
                            state <= ST_READ;
                            reload <= 1'b1;
                        end
                    end
                    ST_DATA:
                    begin
                        data <= rx_byte;
                        data_full <= 1'b1;
                        state <= ST_IGNORE;
                    end
                    ST_READ: reload <= 1'b1;
                    default: state <= ST_IGNORE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path

    logic [6:0] out_shift; // Remaining bits of the byte being sent

    // Drive on falling edges; every byte boundary takes a fresh snapshot
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            miso <= 1'b0;
            miso_en_n <= 1'b1;
            out_shift <= 7'h00;
        end
        else if (!selected)
            miso_en_n <= 1'b1;
        else if (sclk_fall && state == ST_READ)
        begin
            miso_en_n <= 1'b0;
            if (reload)
            begin
                miso <= status_byte[7];
                out_shift <= status_byte[6:0];
            end
            else
            begin
                miso <= out_shift[6];
                out_shift <= {out_shift[5:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command execution at end of frame

    logic whole; // Frame ended on a byte boundary
    logic exec_wren, exec_vwren, exec_write;
    assign whole = cs_end && cmd_full && !byte_odd;
    assign exec_wren = whole && cmd == CMD_WRITE_EN && state == ST_IGNORE;
    assign exec_vwren = whole && cmd == CMD_VOL_WRITE_EN && state == ST_IGNORE;
    assign exec_write = whole && data_full && !busy_flag;

    logic nv_go; // Latched write goes to the non-volatile copy
    assign nv_go = exec_write && write_latch && !vol_enable;

    // Protection fields: reset to zero, then copy in non-volatile image
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            prot <= '{granularity: 1'b0, direction: 1'b0, range: RANGE_RESET};
            load_done <= 1'b0;
        end
        else if (!load_done)
        begin
            prot <= nv_image;
            load_done <= 1'b1;
        end
        else if (exec_write && (write_latch || vol_enable))
            prot <= data[POS_GRANULARITY:POS_RANGE_LO];
    end

    // Volatile arm flag: consumed by the next complete status write
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            vol_enable <= 1'b0;
        else if (exec_vwren)
            vol_enable <= 1'b1;
        else if (exec_wren || exec_write)
            vol_enable <= 1'b0;
    end

    // Non-volatile update timer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            nv_cnt <= 10'h000;
            nv_write_start <= 1'b0;
            nv_write_data <= '0;
        end
        else
        begin
            nv_write_start <= nv_go;
            if (nv_go)
            begin
                nv_cnt <= NV_WRITE_CNT;
                nv_write_data <= data[POS_GRANULARITY:POS_RANGE_LO];
            end
            else if (nv_cnt != 10'h000)
                nv_cnt <= nv_cnt - 10'h001;
        end
    end

    // Busy flag follows internal work one cycle late
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            busy_flag <= 1'b0;
        else
            busy_flag <= ext_busy || nv_go || (nv_cnt != 10'h000);
    end

    ////////////////////////////////////////////////////////////////////////
    // Program and erase gate

    logic pe_ok;
    assign pe_ok = write_latch && !busy_flag && !is_protected(prot, pe_addr);

    // Answer each request with exactly one pulse
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pe_grant <= 1'b0;
            pe_refuse <= 1'b0;
        end
        else
        begin
            pe_grant <= pe_req && pe_ok;
            pe_refuse <= pe_req && !pe_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write latch

    logic op_done; // Accepted operation finished
    assign op_done = op_active && !busy_flag && !nv_go && !(pe_req && pe_ok);

    // Tracks an accepted operation until busy drops
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            op_active <= 1'b0;
        else if (nv_go || (pe_req && pe_ok))
            op_active <= 1'b1;
        else if (op_done && nv_cnt == 10'h000 && !ext_busy)
            op_active <= 1'b0;
    end

    // Set wins over the clear so a late 06h is never lost
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            write_latch <= 1'b0;
        else if (exec_wren)
            write_latch <= 1'b1;
        else if (op_done && nv_cnt == 10'h000 && !ext_busy)
            write_latch <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_reset_clear;
        @(posedge clk) $rose(reset_n) |-> !write_latch && prot.range == RANGE_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("latch or range not cleared");

    property p_wren_sets;
        @(posedge clk) disable iff (!reset_n) exec_wren |=> write_latch;
    endproperty
    a_wren_sets: assert property (p_wren_sets) else $error("06h did not set latch");

    property p_vwren_keeps;
        @(posedge clk) disable iff (!reset_n) exec_vwren && !op_done |=> $stable(write_latch);
    endproperty
    a_vwren_keeps: assert property (p_vwren_keeps) else $error("50h moved latch");

    property p_locked_write;
        @(posedge clk) disable iff (!reset_n)
            load_done && exec_write && !write_latch && !vol_enable |=> $stable(prot);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("write without latch");

    property p_partial_keeps;
        @(posedge clk) disable iff (!reset_n)
            cs_end && byte_odd && write_latch && !op_active |=> write_latch;
    endproperty
    a_partial_keeps: assert property (p_partial_keeps) else $error("abort cleared latch");

    property p_bottom_fine;
        @(posedge clk) disable iff (!reset_n)
            pe_req && prot == protect_t'{1'b1, 1'b0, 3'h1} && pe_addr < 20'h01000 |=> pe_refuse;
    endproperty
    a_bottom_fine: assert property (p_bottom_fine) else $error("low 4 kB not refused");

    property p_top_dir;
        @(posedge clk) disable iff (!reset_n)
            pe_req && prot == protect_t'{1'b1, 1'b1, 3'h1} && pe_addr >= 20'hFF000 |=> pe_refuse;
    endproperty
    a_top_dir: assert property (p_top_dir) else $error("top 4 kB not refused");

    sequence s_nv_run;
        nv_go ##1 busy_flag [*8];
    endsequence
    property p_busy_run;
        @(posedge clk) disable iff (!reset_n) s_nv_run |-> nv_cnt != 10'h000;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy without work");

    property p_done_clears;
        @(posedge clk) disable iff (!reset_n)
            op_done && nv_cnt == 10'h000 && !ext_busy && !exec_wren |=> !write_latch;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept after op");

endmodule : status_one_protect_ready
`default_nettype wire

// File: test/host_spi.sv
// Purpose: Host side serial master driving status register one commands.
// Assumes: SPI mode 0, 32 ns serial period, serial clock idle low.
// Notes: Clock stands still between frames; mosi flips while unused.
`timescale 1ns/1ps
`default_nettype none
module host_spi (
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock
    output logic mosi, // Data to the device
    input wire logic miso // Resolved data from the device
);
    // Idle levels at time zero
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Open a frame; the odd offset keeps serial edges off the core edges
    task automatic start;
        #0.7 cs_n = 1'b0;
    endtask : start
    // Shift n bits MSB first; a short count models an aborted command
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            mosi = b[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
    endtask : bits
    // Take one byte late in the high phase, where miso has long settled
    task automatic get(output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            mosi = ~mosi; // Unused input, kept moving
            #16 sclk = 1'b1;
            #15 b[i] = miso;
            #1 sclk = 1'b0;
        end
    endtask : get
    // Close a frame; the gap is far above the three-cycle minimum
    task automatic stop;
        #16 cs_n = 1'b1;
        mosi = ~mosi;
        #48;
    endtask : stop
endmodule : host_spi
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for status register one.
// Assumes: Host model drives the serial pins; the bench drives the rest.
// Notes: Expected values come from a bench model of the fields.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sr_one_pkg::*;
    logic clk, reset_n; // Core clock, reset active low
    logic ext_busy, pe_req; // Array busy, program request
    logic [19:0] pe_addr, a; // Request address, address under test
    protect_t nv_image, nv_write_data; // Stored copy, value sent to it
    protect_t m_prot, nv_last; // Expected fields, last copy update
    logic m_latch; // Expected write latch
    logic miso, miso_en_n, pe_grant, pe_refuse, nv_write_start; // Device outputs
    wire logic cs_n, sclk, mosi, miso_line; // Serial lines
    int fail_count, checks, cycles, nv_seen, n; // Counters
    logic [31:0] seed, r; // Random state and scratch
    logic [7:0] s, d; // Status read back, data written
    logic [21:0] sz, bnd; // Protected size and boundary
    // Released return line floats; comparisons are four-state
    assign miso_line = miso_en_n ? 1'bz : miso;
    always #2 clk = ~clk;
    status_one_protect_ready dut (.clk(clk), .reset_n(reset_n), .cs_n_pin(cs_n),
        .sclk_pin(sclk), .mosi_pin(mosi), .nv_image(nv_image), .ext_busy(ext_busy),
        .pe_req(pe_req), .pe_addr(pe_addr), .miso(miso), .miso_en_n(miso_en_n),
        .pe_grant(pe_grant), .pe_refuse(pe_refuse), .nv_write_data(nv_write_data),
        .nv_write_start(nv_write_start));
    host_spi host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_line));
    ////////////////////////////////////////////////////////////////////////////////
    // Count copy updates and keep the value handed over
    always @(posedge clk)
        if (nv_write_start === 1'b1)
        begin
            nv_seen++;
            nv_last = nv_write_data;
        end
    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Status byte expected from the model; top bit belongs elsewhere
    function automatic logic [7:0] exp_st(input logic busy);
        return {1'b0, m_prot, m_latch, busy};
    endfunction : exp_st
    // Whether an address lies in the region the settings protect
    function automatic logic prot_hit(input protect_t p, input logic [19:0] ad);
        logic [21:0] z;
        z = (p.granularity ? BLK_FINE : BLK_COARSE) << (p.range - 3'h1);
        if (p.range == 3'h0)
            return 1'b0;
        if (p.range == RANGE_ALL || z >= MEM_BYTES)
            return 1'b1;
        return p.direction ? ({2'h0, ad} >= MEM_BYTES - z) : ({2'h0, ad} < z);
    endfunction : prot_hit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit
    task automatic cmd(input logic [7:0] c);
        host.start();
        host.bits(c, 8);
        host.stop();
    endtask : cmd
    // Status write, direct or through the indirect address
    task automatic wr(input logic [7:0] v, input logic ind);
        host.start();
        if (ind)
        begin
            host.bits(CMD_WRITE_INDIRECT, 8);
            host.bits(REG_ADDR_ONE, 8);
        end
        else
            host.bits(CMD_WRITE_DIRECT, 8);
        host.bits(v, 8);
        host.stop();
    endtask : wr
    task automatic rd(output logic [7:0] v, input logic ind);
        host.start();
        host.bits(ind ? CMD_READ_INDIRECT : CMD_READ_DIRECT, 8);
        if (ind)
            host.bits(REG_ADDR_ONE, 8);
        host.get(v);
        host.stop();
    endtask : rd
    // One-cycle request; the answer stands in the following cycle
    task automatic pe(input logic [19:0] ad, input logic ok);
        @(posedge clk);
        #1 pe_req = 1'b1;
        pe_addr = ad;
        @(posedge clk);
        #1 pe_req = 1'b0;
        chk_bit(pe_grant, ok, "grant");
        chk_bit(pe_refuse, !ok, "refuse");
    endtask : pe
    // Pin syncs need a few quiet cycles before the first frame
    task automatic do_reset;
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        m_prot = nv_image;
        m_latch = 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hE23E7ABB;
        clk = 1'b0;
        reset_n = 1'b0;
        ext_busy = 1'b0;
        pe_req = 1'b0;
        pe_addr = 20'h00000;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        nv_seen = 0;
        r = xs();
        nv_image = r[4:0];
        do_reset();
        rd(s, 1'b0);
        chk_byte(s, exp_st(1'b0), "reset value");
        $display("test reset done");
        r = xs();
        wr(r[7:0], 1'b0);
        rd(s, 1'b1);
        chk_byte(s, exp_st(1'b0), "locked write");
        pe(r[31:12], 1'b0);
        $display("test locked done");
        cmd(CMD_WRITE_EN);
        m_latch = 1'b1;
        rd(s, 1'b0);
        chk_byte(s, exp_st(1'b0), "latch set");
        host.start();
        host.bits(CMD_WRITE_DIRECT, 8);
        host.bits(r[7:0], 5);
        host.stop();
        cmd(CMD_VOL_WRITE_EN);
        rd(s, 1'b1);
        chk_byte(s, exp_st(1'b0), "abort, volatile enable");
        r = xs();
        d = r[7:0];
        wr(d, 1'b1);
        cmd(CMD_WRITE_EN);
        m_prot = d[6:2];
        rd(s, 1'b0);
        chk_byte(s, exp_st(1'b0), "volatile write");
        chk_byte(nv_seen[7:0], 8'h00, "copy untouched");
        r = xs();
        d = r[7:0];
        wr(d, 1'b0);
        m_prot = d[6:2];
        chk_byte(nv_seen[7:0], 8'h01, "copy update");
        chk_byte({3'h0, nv_last}, {3'h0, d[6:2]}, "copy value");
        // Continuing read: poll fresh bytes until the flag drops
        host.start();
        host.bits(CMD_READ_DIRECT, 8);
        host.get(s);
        chk_byte(s, exp_st(1'b1), "busy after write");
        n = 0;
        while (s[0] !== 1'b0 && n < 20)
        begin
            host.get(s);
            n++;
        end
        host.stop();
        chk_bit(s[0], 1'b0, "busy drops");
        m_latch = 1'b0;
        rd(s, 1'b0);
        chk_byte(s, exp_st(1'b0), "latch after write");
        $display("test status write done");
        // Every range code, random direction and size, boundary or random addresses
        for (int i = 0; i < 16; i++)
        begin
            r = xs();
            d = {r[7:5], i[2:0], r[1:0]};
            cmd(CMD_VOL_WRITE_EN);
            wr(d, r[8]);
            cmd(CMD_WRITE_EN);
            m_prot = d[6:2];
            m_latch = 1'b1;
            sz = (m_prot.granularity ? BLK_FINE : BLK_COARSE) << (m_prot.range - 3'h1);
            bnd = m_prot.direction ? MEM_BYTES - sz : sz;
            a = (r[10:9] == 2'h0) ? bnd[19:0] - 20'h1 : (r[10:9] == 2'h1) ? bnd[19:0] : r[31:12];
            pe(a, !prot_hit(m_prot, a));
            if (!prot_hit(m_prot, a))
            begin
                // Busy must rise in the grant cycle or the latch clears at once
                ext_busy = 1'b1;
                pe(r[31:12], 1'b0);
                rd(s, 1'b0);
                chk_byte(s, exp_st(1'b1), "busy flag");
                @(posedge clk);
                #1 ext_busy = 1'b0;
                repeat (4) @(posedge clk);
                m_latch = 1'b0;
                rd(s, 1'b1);
                chk_byte(s, exp_st(1'b0), "after operation");
            end
        end
        // Corner cases: smallest fine region at each end of the array
        for (int k = 0; k < 2; k++)
        begin
            d = {2'h1, k[0], 3'h1, 2'h0};
            cmd(CMD_VOL_WRITE_EN);
            wr(d, k[0]);
            cmd(CMD_WRITE_EN);
            m_prot = d[6:2];
            pe(k[0] ? 20'hFF000 : 20'h00FFF, 1'b0);
            pe(k[0] ? 20'hFEFFF : 20'h01000, 1'b1);
        end
        $display("test protection done");
        cmd(CMD_WRITE_EN);
        do_reset();
        rd(s, 1'b0);
        chk_byte(s, exp_st(1'b0), "second reset");
        $display("test reset again done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
